// ---- verilog/riq_cfg.svh ----
`ifndef RIQ_CFG_SVH
`define RIQ_CFG_SVH
// register offsets
`define RIQ_OFS_CTRL 4'h0
`define RIQ_OFS_FIXQ 4'h1
`define RIQ_OFS_INITQ 4'h2
`define RIQ_OFS_MAXREP 4'h3
`define RIQ_OFS_THRESH 4'h4
`define RIQ_OFS_DWELL 4'h5
`define RIQ_OFS_STATUS 4'h6
`define RIQ_OFS_COUNTS 4'h7
`define RIQ_OFS_SLOT 4'h8
// ctrl fields
`define RIQ_CTRL_START 0
`define RIQ_CTRL_STOP 1
`define RIQ_CTRL_ALG 2
`define RIQ_CTRL_SES_LO 4
`define RIQ_CTRL_SES_HI 5
// reset values and Q limit
`define RIQ_RST_FIXQ 4'h4
`define RIQ_RST_INITQ 4'h4
`define RIQ_RST_MAXREP 16'h00ff
`define RIQ_RST_THI 4'h4
`define RIQ_RST_TLO 4'h1
`define RIQ_RST_DWELL 16'h0190
`define RIQ_Q_MAX 4'hf
// timing: dwell unit 1 ms at 10 MHz
`define RIQ_CLK_HZ 10000000
`define RIQ_MS_CYCLES (`RIQ_CLK_HZ / 1000)
`endif

// ---- verilog/riq_pkg.sv ----
package riq_pkg;
   typedef enum logic [1:0] {
      riq_alg_constant_slot_algorithm,
      riq_alg_adaptive_slot_algorithm
   } riq_alg_t;
   typedef enum logic [2:0] {
      riq_cmd_none,
      riq_cmd_query,
      riq_cmd_query_rep,
      riq_cmd_query_adjust
   } riq_cmd_t;
   typedef struct packed {
      logic rn16_ok;
      logic rn16_timeout;
      logic epc_ok;
      logic epc_timeout;
   } riq_slot_t;
   typedef struct packed {
      riq_cmd_t cmd;
      logic [3:0] q;
      logic [1:0] session;
   } riq_air_t;
endpackage : riq_pkg

// ---- verilog/riq_q_adjust.sv ----
`timescale 1ns/1ps
`include "riq_cfg.svh"
module riq_q_adjust import riq_pkg::*; #(
   parameter int CW = 16
) (
   input wire logic [3:0] q_now,
   input wire logic [CW-1:0] rn16_to,
   input wire logic [CW-1:0] epc_to,
   input wire logic [3:0] thr_hi,
   input wire logic [3:0] thr_lo,
   output logic [3:0] next_q
);
   logic [CW+3:0] prod_hi;
   logic [CW+3:0] prod_lo;
   logic [CW+3:0] rn_w;
   initial begin
      if (CW < 2) $error("counter width too small");
   end
   always_comb begin
      prod_hi = epc_to * thr_hi;
      prod_lo = epc_to * thr_lo;
      rn_w = {4'h0, rn16_to};
      next_q = q_now;
      if (rn_w > prod_hi) begin
         if (q_now != 4'h0) begin
            next_q = q_now - 4'h1;
         end
      end else if (rn_w < prod_lo) begin
         if (q_now != `RIQ_Q_MAX) begin
            next_q = q_now + 4'h1;
         end
      end
   end
endmodule : riq_q_adjust

// ---- verilog/riq_ctrl.sv ----
// What this block does
// - Q held four bits, 0 to 15
// - slot count should exceed tag count
// - fixed-Q and dynamic-Q algorithms selectable
// - fixed-Q rounds use all 2^Q slots
// - round cut off at dwell limit
// - dynamic round: query plus max reps
// - count RN16 and EPC timeouts
// - many RN16 timeouts decrement Q
// - few RN16 timeouts increment Q
// - in between leaves Q unchanged
// - dynamic cycle ends at empty Q0 round
// - separate start Q and fixed Q
// - one of four sessions per round
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "riq_cfg.svh"
module riq_ctrl import riq_pkg::*; #(
   parameter int CW = 16,
   parameter int DWELL_MS_CYCLES = `RIQ_MS_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire riq_slot_t slot_res,
   input wire logic slot_res_vld,
   output riq_air_t air_cmd,
   output logic air_cmd_vld,
   output logic busy
);
   typedef enum logic [2:0] {
      st_idle, st_issue, st_wait, st_eval
   } st_t;
   st_t state;
   logic alg;
   logic [1:0] session;
   logic [3:0] fix_q;
   logic [3:0] init_q;
   logic [15:0] max_rep;
   logic [3:0] thr_hi;
   logic [3:0] thr_lo;
   logic [15:0] dwell_ms;
   logic [3:0] q_cur;
   logic [16:0] slot_idx;
   logic [CW-1:0] rn16_to;
   logic [CW-1:0] epc_to;
   logic [CW-1:0] tags_read;
   logic [15:0] ms_cnt;
   logic [31:0] tick;
   logic cut_off;
   logic [15:0] rounds;
   logic [3:0] next_q;
   logic wr_ctrl;
   logic start_req;
   logic stop_req;
   logic last_slot;
   logic dwell_hit;
   initial begin
      if (CW < 16 || CW > 28) $error("bad counter width");
      if (DWELL_MS_CYCLES < 1) $error("bad ms count");
   end
   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction : hit
   assign wr_ctrl = reg_wr && hit(reg_addr, `RIQ_OFS_CTRL);
   assign start_req = wr_ctrl && reg_wdata[`RIQ_CTRL_START];
   assign stop_req = wr_ctrl && reg_wdata[`RIQ_CTRL_STOP];
   // slot budget: 2^Q slots fixed, 1+max_rep dynamic
   assign last_slot = (alg == 1'b0) ?
      (slot_idx == ((17'h1 << q_cur) - 17'h1)) :
      (slot_idx >= {1'b0, max_rep});
   assign dwell_hit = (dwell_ms != 16'h0) && (ms_cnt >= dwell_ms);
   riq_q_adjust #(.CW(CW)) u_adj (
      .q_now(q_cur),
      .rn16_to(rn16_to),
      .epc_to(epc_to),
      .thr_hi(thr_hi),
      .thr_lo(thr_lo),
      .next_q(next_q)
   );
   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         alg <= 1'b0;
         session <= 2'h0;
         fix_q <= `RIQ_RST_FIXQ;
         init_q <= `RIQ_RST_INITQ;
         max_rep <= `RIQ_RST_MAXREP;
         thr_hi <= `RIQ_RST_THI;
         thr_lo <= `RIQ_RST_TLO;
         dwell_ms <= `RIQ_RST_DWELL;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `RIQ_OFS_CTRL: begin
               if (state == st_idle) begin
                  alg <= reg_wdata[`RIQ_CTRL_ALG];
                  session <= reg_wdata[`RIQ_CTRL_SES_HI:
                     `RIQ_CTRL_SES_LO];
               end
            end
            `RIQ_OFS_FIXQ: fix_q <= reg_wdata[3:0];
            `RIQ_OFS_INITQ: init_q <= reg_wdata[3:0];
            `RIQ_OFS_MAXREP: max_rep <= reg_wdata[15:0];
            `RIQ_OFS_THRESH: begin
               thr_hi <= reg_wdata[7:4];
               thr_lo <= reg_wdata[3:0];
            end
            `RIQ_OFS_DWELL: dwell_ms <= reg_wdata[15:0];
            default: begin
            end
         endcase
      end
   end
   // ----------------------------------------
   // dwell timer
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tick <= 32'h0;
         ms_cnt <= 16'h0;
      end else if (clk_en) begin
         if (state == st_idle || state == st_eval) begin
            tick <= 32'h0;
            ms_cnt <= 16'h0;
         end else if (tick == DWELL_MS_CYCLES - 1) begin
            tick <= 32'h0;
            ms_cnt <= ms_cnt + 16'h1;
         end else begin
            tick <= tick + 32'h1;
         end
      end
   end
   // ----------------------------------------
   // round sequencer
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= st_idle;
         q_cur <= 4'h0;
         slot_idx <= 17'h0;
         rn16_to <= '0;
         epc_to <= '0;
         tags_read <= '0;
         cut_off <= 1'b0;
         rounds <= 16'h0;
         air_cmd <= '0;
         air_cmd_vld <= 1'b0;
         busy <= 1'b0;
      end else if (clk_en) begin
         air_cmd_vld <= 1'b0;
         case (state)
            st_idle: begin
               if (start_req) begin
                  q_cur <= reg_wdata[`RIQ_CTRL_ALG] ? init_q : fix_q;
                  slot_idx <= 17'h0;
                  rn16_to <= '0;
                  epc_to <= '0;
                  tags_read <= '0;
                  cut_off <= 1'b0;
                  rounds <= 16'h0;
                  busy <= 1'b1;
                  state <= st_issue;
               end
            end
            st_issue: begin
               if (stop_req) begin
                  busy <= 1'b0;
                  state <= st_idle;
               end else begin
                  air_cmd.cmd <= (slot_idx == 17'h0) ?
                     riq_cmd_query : riq_cmd_query_rep;
                  air_cmd.q <= q_cur;
                  air_cmd.session <= session;
                  air_cmd_vld <= 1'b1;
                  state <= st_wait;
               end
            end
            st_wait: begin
               if (stop_req) begin
                  busy <= 1'b0;
                  state <= st_idle;
               end else if (dwell_hit) begin
                  cut_off <= 1'b1;
                  busy <= 1'b0;
                  state <= st_idle;
               end else if (slot_res_vld) begin
                  if (slot_res.rn16_timeout) begin
                     rn16_to <= rn16_to + 1'b1;
                  end
                  if (slot_res.epc_timeout) begin
                     epc_to <= epc_to + 1'b1;
                  end
                  if (slot_res.epc_ok) begin
                     tags_read <= tags_read + 1'b1;
                  end
                  if (last_slot) begin
                     state <= st_eval;
                  end else begin
                     slot_idx <= slot_idx + 17'h1;
                     state <= st_issue;
                  end
               end
            end
            st_eval: begin
               rounds <= rounds + 16'h1;
               slot_idx <= 17'h0;
               rn16_to <= '0;
               epc_to <= '0;
               tags_read <= '0;
               if (stop_req) begin
                  busy <= 1'b0;
                  state <= st_idle;
               end else if (alg && q_cur == 4'h0 && tags_read == '0) begin
                  busy <= 1'b0;
                  state <= st_idle;
               end else begin
                  if (alg) begin
                     q_cur <= next_q;
                  end
                  state <= st_issue;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end
   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0;
      end else if (clk_en) begin
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `RIQ_OFS_CTRL: reg_rdata <= {26'h0, session, 1'b0, alg,
                  2'h0};
               `RIQ_OFS_FIXQ: reg_rdata <= {28'h0, fix_q};
               `RIQ_OFS_INITQ: reg_rdata <= {28'h0, init_q};
               `RIQ_OFS_MAXREP: reg_rdata <= {16'h0, max_rep};
               `RIQ_OFS_THRESH: reg_rdata <= {24'h0, thr_hi, thr_lo};
               `RIQ_OFS_DWELL: reg_rdata <= {16'h0, dwell_ms};
               `RIQ_OFS_STATUS: reg_rdata <= {rounds, 8'h0, q_cur,
                  2'h0, cut_off, busy};
               `RIQ_OFS_COUNTS: reg_rdata <= {rn16_to[15:0], epc_to[15:0]};
               `RIQ_OFS_SLOT: reg_rdata <= {15'h0, slot_idx};
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_q_sat;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_eval && alg && q_cur == 4'hf &&
         !({4'h0, rn16_to} > epc_to * thr_hi)) |=> (q_cur == 4'hf);
   endproperty
   a_q_sat: assert property (p_q_sat) else $error("q overflow");
   property p_q_floor;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_eval && alg && !stop_req && q_cur == 4'h0 &&
         {4'h0, rn16_to} > epc_to * thr_hi) |=> (q_cur == 4'h0);
   endproperty
   a_q_floor: assert property (p_q_floor) else $error("q underflow");
   property p_fixed_q;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_eval && !alg) |=> $stable(q_cur);
   endproperty
   a_fixed_q: assert property (p_fixed_q) else $error("fixed q moved");
   property p_query_first;
      @(posedge mclk) disable iff (sys_rst)
      (air_cmd_vld && $past(slot_idx) == 17'h0)
         |-> air_cmd.cmd == riq_cmd_query;
   endproperty
   a_query_first: assert property (p_query_first)
      else $error("round not opened by query");
   property p_cut;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_wait && dwell_hit && !stop_req)
         |=> (cut_off && !busy);
   endproperty
   a_cut: assert property (p_cut) else $error("dwell not enforced");
   property p_end;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_eval && alg && q_cur == 4'h0 &&
         tags_read == '0) |=> !busy;
   endproperty
   a_end: assert property (p_end) else $error("cycle did not end");
   property p_dec;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_eval && alg && !stop_req && q_cur != 4'h0 &&
         {4'h0, rn16_to} > epc_to * thr_hi) |=> q_cur == $past(q_cur) - 4'h1;
   endproperty
   a_dec: assert property (p_dec) else $error("q not decremented");
   property p_inc;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && state == st_eval && alg && !stop_req && q_cur != 4'hf &&
         {4'h0, rn16_to} < epc_to * thr_lo &&
         !({4'h0, rn16_to} > epc_to * thr_hi))
         |=> q_cur == $past(q_cur) + 4'h1;
   endproperty
   a_inc: assert property (p_inc) else $error("q not incremented");
   property p_sess;
      @(posedge mclk) disable iff (sys_rst)
      air_cmd_vld |-> air_cmd.session == session;
   endproperty
   a_sess: assert property (p_sess) else $error("session mismatch");
endmodule : riq_ctrl

// ---- tb/riq_tag_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// tag population across the air interface
// ----------------------------------------
module riq_tag_model import riq_pkg::*; (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire riq_air_t air_cmd,
   input wire logic air_cmd_vld,
   input wire logic crowd,
   input wire logic [3:0] n_tags,
   input wire logic [1:0] lag,
   output riq_slot_t slot_res,
   output logic slot_res_vld
);
   logic [15:0] cnt [16];
   logic [15:0] done_tag [4];
   logic [15:0] lfsr, seed;
   riq_slot_t ans;
   logic [2:0] wait_c;
   int hits, who;
   // one inventoried flag set per session
   always @(posedge mclk) begin
      slot_res_vld <= !sys_rst && !air_cmd_vld && (wait_c == 3'h1);
      if (sys_rst) begin
         wait_c <= 3'h0;
         for (int s = 0; s < 4; s++) begin
            done_tag[s] <= 16'h0;
         end
         lfsr <= 16'hace1;
         slot_res <= 4'h0;
      end else begin
         // result bus shows garbage unless a reply is due
         slot_res <= (wait_c == 3'h1) ? ans : ~slot_res;
         if (air_cmd_vld) begin
            hits = 0;
            for (int i = 0; i < 16; i++) begin
               seed = lfsr ^ 16'(i * 7919);
               if (air_cmd.cmd == riq_cmd_query)
                  cnt[i] = seed & ((16'h1 << air_cmd.q) - 16'h1);
               else if (cnt[i] == 16'h0)
                  cnt[i] = 16'hffff;
               else
                  cnt[i] = cnt[i] - 16'h1;
               if (i < n_tags && !done_tag[air_cmd.session][i] &&
                  cnt[i] == 16'h0) begin
                  hits++;
                  who = i;
               end
            end
            if (air_cmd.cmd == riq_cmd_query)
               lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            if (crowd || hits > 1) begin
               ans <= 4'h9;
            end else if (hits == 1) begin
               ans <= 4'ha;
               done_tag[air_cmd.session][who] <= 1'h1;
            end else begin
               ans <= 4'h4;
            end
            wait_c <= 3'(lag) + 3'h1;
         end else if (wait_c != 3'h0) begin
            wait_c <= wait_c - 3'h1;
         end
      end
   end
endmodule : riq_tag_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import riq_pkg::*; ;
   logic mclk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
   logic crowd = 1'h0, slot_res_vld, air_cmd_vld, busy;
   logic [3:0] reg_addr = 4'h0, n_tags = 4'h0;
   logic [1:0] lag = 2'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   riq_slot_t slot_res;
   riq_air_t air_cmd;
   riq_air_t cq[$];
   logic [3:0] ra [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
   logic [31:0] rv [7] = '{32'h4, 32'h4, 32'hff, 32'h41, 32'h190, 32'h0,
      32'h0};
   int n_fail = 0, checks = 0;
   always #50 mclk = ~mclk;
   riq_ctrl #(.DWELL_MS_CYCLES(10)) DUT (.mclk(mclk), .sys_rst(sys_rst),
      .clk_en(1'h1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .slot_res(slot_res), .slot_res_vld(slot_res_vld), .air_cmd(air_cmd),
      .air_cmd_vld(air_cmd_vld), .busy(busy));
   riq_tag_model u_tags (.mclk(mclk), .sys_rst(sys_rst), .air_cmd(air_cmd),
      .air_cmd_vld(air_cmd_vld), .crowd(crowd), .n_tags(n_tags), .lag(lag),
      .slot_res(slot_res), .slot_res_vld(slot_res_vld));
   always @(posedge mclk) if (air_cmd_vld) cq.push_back(air_cmd);
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      @(negedge mclk);
      d = reg_rdata;
   endtask : rd
   task automatic go(logic [31:0] ctrl, int stop_at);
      cq = {};
      wr(4'h0, ctrl);
      for (int n = 0; n < 5000; n++) begin
         @(negedge mclk);
         if (busy !== 1'h1) return;
         if (stop_at > 0 && cq.size() >= stop_at) wr(4'h0, 32'h2);
      end
      chk("busy", {31'h0, busy}, 32'h0);
   endtask : go
   task automatic cmd(int i, riq_cmd_t c, logic [3:0] q);
      chk("cmd", 32'(cq[i].cmd), 32'(c));
      if (c == riq_cmd_query) chk("q", 32'(cq[i].q), 32'(q));
   endtask : cmd
   task automatic results;
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   initial begin
      #8000000;
      n_fail++;
      results();
   end
   initial begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'h0;
      foreach (ra[i]) begin
         rd(ra[i]);
         chk("reg", d, rv[i]);
      end
      n_tags <= 4'h3;
      wr(4'h1, 32'h2);
      wr(4'h5, 32'h0);
      go(32'h11, 8);
      chk("session", 32'(cq[0].session), 32'h1);
      for (int i = 0; i < 5; i++) begin
         cmd(i, i % 4 ? riq_cmd_query_rep : riq_cmd_query, 4'h2);
      end
      n_tags <= 4'h0;
      wr(4'h2, 32'h3);
      wr(4'h3, 32'h1);
      go(32'h25, 0);
      chk("cmds", 32'(cq.size()), 32'h8);
      chk("session", 32'(cq[0].session), 32'h2);
      for (int i = 0; i < 8; i++) begin
         cmd(i, i % 2 ? riq_cmd_query_rep : riq_cmd_query,
            4'(3 - i / 2));
      end
      crowd <= 1'h1;
      wr(4'h2, 32'he);
      go(32'h35, 6);
      chk("session", 32'(cq[0].session), 32'h3);
      for (int i = 0; i < 6; i += 2) begin
         cmd(i, riq_cmd_query, i > 0 ? 4'hf : 4'he);
      end
      wr(4'h4, 32'h40);
      go(32'h05, 6);
      for (int i = 0; i < 6; i += 2) begin
         cmd(i, riq_cmd_query, 4'he);
      end
      crowd <= 1'h0;
      n_tags <= 4'h1;
      lag <= 2'h2;
      wr(4'h2, 32'h0);
      wr(4'h3, 32'h3);
      wr(4'h4, 32'h41);
      go(32'h05, 0);
      chk("idle", {31'h0, busy}, 32'h0);
      chk("cmds", 32'(cq.size()), 32'h8);
      for (int i = 0; i < 8; i += 4) begin
         cmd(i, riq_cmd_query, 4'h0);
      end
      lag <= 2'h3;
      wr(4'h1, 32'hf);
      wr(4'h5, 32'h2);
      go(32'h01, 0);
      rd(4'h6);
      chk("cut_off", {30'h0, d[1:0]}, 32'h2);
      chk("short", 32'(cq.size() < 16), 32'h1);
      results();
   end
endmodule : tb_top
